/* core/event_triggered_down_timer.sv */
module event_triggered_down_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Transmitter and receiver events
  input wire logic tx_first_bit_event,
  input wire logic tx_last_bit_event,
  input wire logic rx_first_bit_event,
  input wire logic rx_last_bit_event,
  // Timer status
  output logic count_expired_irq,
  output logic count_active_flag,
  output logic [7:0] current_count
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] timer_prescale_config;
  logic [7:0] timer_event_select;
  logic [7:0] timer_preload_value;
  logic sw_start_now;
  logic sw_stop_now;
  logic tick;
  logic start_any;
  logic stop_any;
  logic auto_reload_enable;
  logic [4:0] clock_divider_exp;
  logic [7:0] reload_count;
  logic [7:0] next_count;
  logic next_active;
  logic next_irq;
  logic wr_control;

  assign auto_reload_enable = timer_prescale_config[timer_pkg::BIT_AUTO_RELOAD];
  assign clock_divider_exp = timer_prescale_config[timer_pkg::EXP_LSB +: timer_pkg::EXP_W];
  assign reload_count = timer_preload_value;
  assign wr_control = reg_wr && (reg_addr == timer_pkg::ADDR_CMD_CONTROL);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Plain storage: none of these touch the running count directly
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      timer_prescale_config <= timer_pkg::RST_PRESCALE_CONFIG;
      timer_event_select <= timer_pkg::RST_EVENT_SELECT;
      timer_preload_value <= timer_pkg::RST_PRELOAD_VALUE;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        timer_pkg::ADDR_PRESCALE_CONFIG: timer_prescale_config <= reg_wdata & 8'h3F;
        timer_pkg::ADDR_EVENT_SELECT: timer_event_select <= reg_wdata & 8'h0F;
        timer_pkg::ADDR_PRELOAD_VALUE: timer_preload_value <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software commands
  // ----------------------------------------------------------------
  // Command bits live one cycle only, so each write is one event
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sw_start_now <= 1'b0;
      sw_stop_now <= 1'b0;
    end
    else
    begin
      sw_start_now <= wr_control && reg_wdata[timer_pkg::BIT_SW_START];
      sw_stop_now <= wr_control && reg_wdata[timer_pkg::BIT_SW_STOP];
    end
  end

  // ----------------------------------------------------------------
  // Event combination and timer clock
  // ----------------------------------------------------------------
  timer_event_gate #(
    .N(3)
  ) start_gate (
    .events({sw_start_now, tx_last_bit_event, tx_first_bit_event}),
    .enables({1'b1, timer_event_select[timer_pkg::BIT_START_TX_LAST],
              timer_event_select[timer_pkg::BIT_START_TX_FIRST]}),
    .hit(start_any)
  );

  timer_event_gate #(
    .N(3)
  ) stop_gate (
    .events({sw_stop_now, rx_last_bit_event, rx_first_bit_event}),
    .enables({1'b1, timer_event_select[timer_pkg::BIT_STOP_RX_LAST],
              timer_event_select[timer_pkg::BIT_STOP_RX_FIRST]}),
    .hit(stop_any)
  );

  // Prescaler phase restarts on each start, so every period is whole
  timer_prescaler #(
    .CNT_W(timer_pkg::PRESCALE_CNT_W)
  ) prescaler (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(start_any),
    .exp_sel(clock_divider_exp),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Counter next state
  // ----------------------------------------------------------------
  // Stop beats start in the same cycle; an early stop also swallows
  // the expiry that the same tick would have raised
  always_comb
  begin
    next_count = current_count;
    next_active = count_active_flag;
    next_irq = 1'b0;
    if (stop_any)
    begin
      next_active = 1'b0;
    end
    else if (start_any)
    begin
      next_count = reload_count;
      next_active = 1'b1;
    end
    else if (count_active_flag && tick)
    begin
      if (current_count == 8'h01)
      begin
        next_irq = 1'b1;
        if (auto_reload_enable)
        begin
          next_count = reload_count;
        end
        else
        begin
          next_count = 8'h00;
          next_active = 1'b0;
        end
      end
      else if (current_count == 8'h00)
      begin
        // A zero preload just halts; no step from one, so no request
        next_active = 1'b0;
      end
      else
      begin
        next_count = current_count - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter state
  // ----------------------------------------------------------------
  // Count value changes only through the next-state logic above
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      current_count <= timer_pkg::RST_COUNT;
    end
    else
    begin
      current_count <= next_count;
    end
  end

  // Running flag
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count_active_flag <= 1'b0;
    end
    else
    begin
      count_active_flag <= next_active;
    end
  end

  // Expiry request: one-cycle pulse for the chip's interrupt unit
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count_expired_irq <= 1'b0;
    end
    else
    begin
      count_expired_irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Register readback
  // ----------------------------------------------------------------
  // Registered read data; command bits and unmapped addresses read zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        timer_pkg::ADDR_AUX_STATUS: reg_rdata <= {count_active_flag, 7'h00};
        timer_pkg::ADDR_CMD_CONTROL: reg_rdata <= 8'h00;
        timer_pkg::ADDR_COUNT_READBACK: reg_rdata <= current_count;
        timer_pkg::ADDR_PRESCALE_CONFIG: reg_rdata <= timer_prescale_config;
        timer_pkg::ADDR_EVENT_SELECT: reg_rdata <= timer_event_select;
        timer_pkg::ADDR_PRELOAD_VALUE: reg_rdata <= timer_preload_value;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic quiet;
  assign quiet = !start_any && !stop_any;

  sequence step_from_one;
    count_active_flag && tick && quiet && (current_count == 8'h01);
  endsequence

  sequence sw_start_write;
    wr_control && reg_wdata[timer_pkg::BIT_SW_START];
  endsequence

  sequence sw_stop_write;
    wr_control && reg_wdata[timer_pkg::BIT_SW_STOP];
  endsequence

  // Restart with divider two: one cycle without a tick, then the first tick
  sequence restart_div2;
    start_any ##1 (quiet && (clock_divider_exp == 5'h01))
    ##1 (clock_divider_exp == 5'h01);
  endsequence

  AST_DECREMENT:
    assert property (count_active_flag && tick && quiet && (current_count > 8'h01)
                     |=> current_count == $past(current_count) - 8'h01)
    else $error("running count did not decrement on tick");

  AST_RELOAD_AT_ONE:
    assert property (step_from_one and auto_reload_enable
                     |=> (current_count == $past(reload_count)) && count_active_flag
                         && count_expired_irq)
    else $error("auto reload did not reload at one");

  AST_START_LOADS:
    assert property (start_any && !stop_any
                     |=> (current_count == $past(reload_count)) && count_active_flag)
    else $error("start event did not load preload");

  AST_STOP_HALTS:
    assert property (stop_any |=> !count_active_flag && !count_expired_irq)
    else $error("stop event did not halt the counter");

  AST_IDLE_HOLDS:
    assert property (!count_active_flag && !start_any
                     |=> $stable(current_count) && !count_expired_irq)
    else $error("count changed while not running");

  AST_SW_STOP_NO_IRQ:
    assert property (sw_stop_now |=> !count_expired_irq)
    else $error("software stop raised expiry request");

  AST_EXPIRE:
    assert property (step_from_one and !auto_reload_enable
                     |=> count_expired_irq && (current_count == 8'h00)
                         && !count_active_flag)
    else $error("expiry at zero not flagged");

  AST_IRQ_CAUSE:
    assert property (count_expired_irq
                     |-> $past(current_count) == 8'h01 && $past(count_active_flag)
                         && $past(tick))
    else $error("expiry request without step from one");

  AST_SW_START_PULSE:
    assert property (sw_start_write ##1 !(wr_control && reg_wdata[timer_pkg::BIT_SW_START])
                     |-> sw_start_now ##1 !sw_start_now)
    else $error("software start not a single pulse");

  AST_TICK_EXP0:
    assert property (clock_divider_exp == 5'h00 |-> tick)
    else $error("undivided timer clock missed a tick");

  AST_READBACK:
    assert property (reg_rd && (reg_addr == timer_pkg::ADDR_COUNT_READBACK)
                     |=> reg_rdata == $past(current_count))
    else $error("count readback mismatch");

  AST_PRELOAD_WRITE_NO_EFFECT:
    assert property (reg_wr && (reg_addr == timer_pkg::ADDR_PRELOAD_VALUE)
                     && !count_active_flag && !start_any
                     |=> current_count == $past(current_count))
    else $error("preload write disturbed the count");

  AST_SW_STOP_PULSE:
    assert property (sw_stop_write ##1 !(wr_control && reg_wdata[timer_pkg::BIT_SW_STOP])
                     |-> sw_stop_now ##1 !sw_stop_now)
    else $error("software stop not a single pulse");

  AST_STOP_BEATS_START:
    assert property (start_any && stop_any
                     |=> !count_active_flag && $stable(current_count))
    else $error("start overrode a stop in the same cycle");

  AST_ZERO_HALT:
    assert property (count_active_flag && tick && quiet && (current_count == 8'h00)
                     |=> !count_active_flag && !count_expired_irq)
    else $error("zero preload did not halt quietly");

  AST_TICK_DIV2:
    assert property (restart_div2 |-> tick && !$past(tick))
    else $error("divided timer clock out of phase after restart");

  AST_FLAG_RISE:
    assert property ($rose(count_active_flag) |-> $past(start_any))
    else $error("running flag rose without a start event");

  AST_PRELOAD_LANDS:
    assert property (reg_wr && (reg_addr == timer_pkg::ADDR_PRELOAD_VALUE)
                     |=> reload_count == $past(reg_wdata))
    else $error("preload write was lost");

endmodule

/* core/timer_event_gate.sv */
module timer_event_gate #(
  parameter int N = 3
) (
  // Events and their enables
  input wire logic [N-1:0] events,
  input wire logic [N-1:0] enables,
  // Combined event
  output logic hit
);

  // Any enabled event counts; an always-on source ties its enable high
  assign hit = |(events & enables);

endmodule

/* core/timer_pkg.sv */
// Functional notes
// - Running nonzero count decrements each timer tick
// - Auto-reload: at one, reload instead of zero
// - Enabled start event loads preload and starts
// - Every start event with no stop in its cycle retriggers from preload
// - Enabled stop events or zero halt counter
// - Preload or settings writes leave count untouched
// - Software stop never raises expiry request
// - Tick is clock divided by two^exp, exp<=21
// - Active flag set on start, cleared on stop
// - Current count always readable by software
// - Reaching zero without stop raises expiry request
// - Early stop event halts without expiry request
// - Auto-reload gives one request per period
// - Request on step one-to-zero or one-to-preload
package timer_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_AUX_STATUS = 6'h05;
  localparam logic [5:0] ADDR_CMD_CONTROL = 6'h09;
  localparam logic [5:0] ADDR_COUNT_READBACK = 6'h0C;
  localparam logic [5:0] ADDR_PRESCALE_CONFIG = 6'h2A;
  localparam logic [5:0] ADDR_EVENT_SELECT = 6'h2B;
  localparam logic [5:0] ADDR_PRELOAD_VALUE = 6'h2C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ACTIVE_FLAG = 7;
  localparam int BIT_SW_START = 1;
  localparam int BIT_SW_STOP = 2;
  localparam int BIT_AUTO_RELOAD = 5;
  localparam int EXP_LSB = 0;
  localparam int EXP_W = 5;
  localparam int BIT_START_TX_FIRST = 0;
  localparam int BIT_START_TX_LAST = 1;
  localparam int BIT_STOP_RX_FIRST = 2;
  localparam int BIT_STOP_RX_LAST = 3;

  // ----------------------------------------------------------------
  // Values after reset and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PRESCALE_CONFIG = 8'h00;
  localparam logic [7:0] RST_EVENT_SELECT = 8'h00;
  localparam logic [7:0] RST_PRELOAD_VALUE = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [4:0] MAX_DIVIDER_EXP = 5'h15;
  localparam int PRESCALE_CNT_W = 22;

  // Nominal chip clock, kept for reference; the divider runs from clk_sys
  localparam int CHIP_CLK_KHZ = 13560;
  localparam int SYS_CLK_KHZ = 20000;

endpackage

/* core/timer_prescaler.sv */
module timer_prescaler #(
  parameter int CNT_W = timer_pkg::PRESCALE_CNT_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic restart,
  input wire logic [4:0] exp_sel,
  // Enable out
  output logic tick
);

  logic [CNT_W-1:0] phase;
  logic [CNT_W-1:0] mask;
  logic [4:0] exp_eff;

  // Out-of-range exponents clamp so the mask never exceeds the counter
  assign exp_eff = (exp_sel > timer_pkg::MAX_DIVIDER_EXP) ? timer_pkg::MAX_DIVIDER_EXP
                                                          : exp_sel;
  assign mask = ~({CNT_W{1'b1}} << exp_eff);
  assign tick = ((phase & mask) == mask);

  // Free-running phase; a restart aligns the first tick to the load
  always_ff @(posedge clk_sys)
  begin
    if (rst || restart)
    begin
      phase <= '0;
    end
    else
    begin
      phase <= phase + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

/* testbench/event_triggered_down_timer_bench.sv */
module event_triggered_down_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // ------
  // Signals
  // ------
  typedef struct {int src; int e; int r; int t;} row_type;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [5:0] reg_addr = 6'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [3:0] fire = 4'h0;
  logic tx_first_bit_event, tx_last_bit_event, rx_first_bit_event, rx_last_bit_event;
  logic count_expired_irq, count_active_flag;
  logic [7:0] current_count, v;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  int irq_cnt = 0;
  int n, i0;
  // Sources: 0 first tx bit, 1 last tx bit, 2 software; reload 1 and 255 are the edges
  // Last field: edges from load to the expiry pulse, one plus reload times 2^exp
  row_type rows[4] = '{'{0, 0, 2, 3}, '{1, 2, 5, 21}, '{2, 1, 1, 3}, '{0, 3, 255, 2041}};
  logic [5:0] regs[7] = '{6'h05, 6'h09, 6'h0C, 6'h2A, 6'h2B, 6'h2C, 6'h3F};

  timer_event_model model (.clk_sys(clk_sys), .rst(rst), .fire(fire),
    .tx_first_bit_event(tx_first_bit_event), .tx_last_bit_event(tx_last_bit_event),
    .rx_first_bit_event(rx_first_bit_event), .rx_last_bit_event(rx_last_bit_event));

  event_triggered_down_timer dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_first_bit_event(tx_first_bit_event), .tx_last_bit_event(tx_last_bit_event),
    .rx_first_bit_event(rx_first_bit_event), .rx_last_bit_event(rx_last_bit_event),
    .count_expired_irq(count_expired_irq), .count_active_flag(count_active_flag),
    .current_count(current_count));

  // ------
  // Tasks
  // ------
  task close_out;
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Strobe drops at the next edge, so back-to-back calls leave one idle cycle
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task pulse(input logic [3:0] f);
    @(posedge clk_sys);
    fire <= f;
    @(posedge clk_sys);
    fire <= 4'h0;
  endtask

  // Event and software starts both load the count one edge after return
  task start(input int src);
    if (src < 2)
      pulse(4'(1 << src));
    else
      wr(timer_pkg::ADDR_CMD_CONTROL, 8'h02);
  endtask

  task cfg(input logic [4:0] e, input logic a, input logic [7:0] s, input logic [7:0] r);
    wr(timer_pkg::ADDR_PRESCALE_CONFIG, {2'b00, a, e});
    wr(timer_pkg::ADDR_EVENT_SELECT, s);
    wr(timer_pkg::ADDR_PRELOAD_VALUE, r);
  endtask

  // Bounded wait for the expiry pulse, counting edges
  task wait_irq(output int k);
    k = 0;
    repeat (4000)
    begin
      @(posedge clk_sys);
      k++;
      #1;
      if (count_expired_irq === 1'b1)
        break;
    end
  endtask

  // ------
  // Clock, monitors and sequence
  // ------
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Counts expiry pulses and cuts a hang short
  always @(posedge clk_sys)
  begin
    cycles++;
    if (count_expired_irq === 1'b1)
      irq_cnt++;
    if (cycles == 30000)
    begin
      error_cnt++;
      close_out;
    end
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk("flag", count_active_flag, 0); // Idle after reset
    foreach (regs[i])
    begin
      rd(regs[i], v);
      chk("reset reg", v, 0); // Cleared registers
    end
    wr(6'h2A, 8'hFF);
    rd(6'h2A, v);
    chk("prescale", v, 8'h3F); // Divider exponent and auto-reload bits
    wr(6'h2B, 8'hFF);
    rd(6'h2B, v);
    chk("select", v, 8'h0F); // Four enables
    wr(6'h0C, 8'h55);
    rd(6'h0C, v);
    chk("count ro", v, 0); // Readback is read-only
    // Ordinary one-shot runs from each start source
    foreach (rows[i])
    begin
      cfg(5'(rows[i].e), 1'b0, 8'h03, 8'(rows[i].r));
      start(rows[i].src);
      wait_irq(n);
      chk("expiry time", n, rows[i].t);
      chk("flag at zero", count_active_flag, 0);
      chk("count at zero", current_count, 0);
      @(posedge clk_sys);
      #1 chk("irq width", count_expired_irq, 0); // One pulse
    end
    // Receive stop before zero; a disabled stop is ignored
    cfg(5'h00, 1'b0, 8'h05, 8'h28);
    i0 = irq_cnt;
    start(0);
    repeat (4) @(posedge clk_sys);
    pulse(4'h8);
    @(posedge clk_sys);
    #1 chk("disabled stop", count_active_flag, 1);
    pulse(4'h4);
    repeat (2) @(posedge clk_sys);
    #1 v = current_count;
    chk("rx stop", count_active_flag, 0);
    repeat (50) @(posedge clk_sys);
    #1 chk("count held", current_count, v);
    chk("no irq", irq_cnt, i0);
    chk("stopwatch", 8'(8'h28 - v), 8'h08); // Eight ticks load to stop
    rd(6'h0C, n);
    chk("count reg", n[7:0], v);
    // Software stop mid-count raises nothing
    cfg(5'h00, 1'b0, 8'h00, 8'h1E);
    start(2);
    rd(6'h05, v);
    chk("status bit", v, 8'h80);
    wr(6'h09, 8'h04);
    repeat (2) @(posedge clk_sys);
    #1 chk("sw stop", count_active_flag, 0);
    rd(6'h09, v);
    chk("cmd bits", v, 0); // Self-clearing
    repeat (40) @(posedge clk_sys);
    chk("no irq sw", irq_cnt, i0);
    // New preload leaves the count alone until a retrigger
    cfg(5'h00, 1'b0, 8'h01, 8'h0C);
    start(0);
    repeat (3) @(posedge clk_sys);
    wr(6'h2C, 8'h14);
    #1 chk("count kept", current_count, 8'h08); // Four ticks since load
    pulse(4'h1);
    @(posedge clk_sys);
    #1 chk("retrigger", current_count, 8'h14);
    wait_irq(n);
    chk("retrig time", n, 20);
    // Periodic mode with divider 2, reload 3
    cfg(5'h01, 1'b1, 8'h01, 8'h03);
    i0 = irq_cnt;
    start(0);
    wait_irq(n);
    chk("first period", n, 7); // One-shot wait
    chk("reloaded", current_count, 3);
    repeat (2)
    begin
      wait_irq(n);
      chk("period", n, 6);
      chk("still active", count_active_flag, 1);
    end
    wr(6'h09, 8'h04);
    repeat (2) @(posedge clk_sys);
    #1 chk("pulses", irq_cnt - i0, 3);
    chk("auto stop", count_active_flag, 0);
    // Start and enabled last-bit stop in one cycle: the stop wins, no reload
    cfg(5'h00, 1'b0, 8'h09, 8'h28);
    start(0);
    repeat (2) @(posedge clk_sys);
    pulse(4'h9);
    @(posedge clk_sys);
    #1 chk("stop wins", count_active_flag, 0);
    chk("no reload", current_count, 8'h25);
    // Zero preload halts on the first tick without a request
    cfg(5'h00, 1'b0, 8'h01, 8'h00);
    i0 = irq_cnt;
    start(0);
    repeat (2) @(posedge clk_sys);
    #1 chk("zero halt", count_active_flag, 0);
    repeat (3) @(posedge clk_sys);
    chk("zero no irq", irq_cnt, i0);
    // Reset in mid-count clears the run and the settings
    cfg(5'h00, 1'b0, 8'h01, 8'h50);
    start(0);
    repeat (3) @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk("reset flag", count_active_flag, 0);
    chk("reset count", current_count, 0);
    rd(6'h2C, v);
    chk("reset preload", v, 0);
    close_out;
  end
endmodule

/* testbench/timer_event_model.sv */
module timer_event_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Requests from the bench, one bit per event
  input wire logic [3:0] fire,
  // Events as the transmitter and receiver raise them
  output logic tx_first_bit_event,
  output logic tx_last_bit_event,
  output logic rx_first_bit_event,
  output logic rx_last_bit_event
);
  timeunit 1ns;
  timeprecision 1ns;

  // Each event is a one-cycle pulse launched off the clock edge
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      {rx_last_bit_event, rx_first_bit_event, tx_last_bit_event, tx_first_bit_event} <= 4'h0;
    end
    else
    begin
      {rx_last_bit_event, rx_first_bit_event, tx_last_bit_event, tx_first_bit_event} <= fire;
    end
  end
endmodule
